// ==== doc_pkg.sv ====
// package for the output setup register and slew limiter
// assumes one 25 MHz system clock shared by all users
package doc_pkg;
  // ==========================================================
  // register map
  localparam logic [4:0] OUTPUT_SETUP_ADDR = 5'h06;
  localparam logic [23:0] OUTPUT_SETUP_RESET = 24'h06_0c00;
  localparam int FAULT_BIT = 21;
  localparam int ADDR_LSB = 16;
  localparam int STEP_LSB = 13;
  localparam int RATE_LSB = 9;
  localparam int SLEW_ON_BIT = 8;
  localparam int EXT_RES_BIT = 7;
  localparam int OUT_EN_BIT = 6;
  localparam int BUF_EN_BIT = 5;
  localparam int OVR_BIT = 4;
  localparam logic [2:0] STEP_RESET = 3'h0;
  localparam logic [3:0] RATE_RESET = 4'h6;
  localparam logic [3:0] RANGE_RESET = 4'h0;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int REFRESH_US = 100;
  localparam int REFRESH_CYC = CLK_HZ / 1_000_000 * REFRESH_US;
  // ==========================================================
  // slew step size in lsb per update
  function automatic logic [15:0] step_lsb(input logic [2:0] c);
    case (c)
      3'h0: step_lsb = 16'h0004;
      3'h1: step_lsb = 16'h000c;
      3'h2: step_lsb = 16'h0040;
      3'h3: step_lsb = 16'h0078;
      3'h4: step_lsb = 16'h0100;
      3'h5: step_lsb = 16'h01f4;
      3'h6: step_lsb = 16'h071c;
      default: step_lsb = 16'h0800;
    endcase
  endfunction : step_lsb
  // update rate in hz
  function automatic int rate_hz(input logic [3:0] c);
    case (c)
      4'h0: rate_hz = 240_000;
      4'h1: rate_hz = 200_000;
      4'h2: rate_hz = 150_000;
      4'h3: rate_hz = 128_000;
      4'h4: rate_hz = 64_000;
      4'h5: rate_hz = 32_000;
      4'h6: rate_hz = 16_000;
      4'h7: rate_hz = 8_000;
      4'h8: rate_hz = 4_000;
      4'h9: rate_hz = 2_000;
      4'ha: rate_hz = 1_000;
      4'hb: rate_hz = 512;
      4'hc: rate_hz = 256;
      4'hd: rate_hz = 128;
      4'he: rate_hz = 64;
      default: rate_hz = 16;
    endcase
  endfunction : rate_hz
  function automatic logic range_valid(input logic [3:0] r);
    range_valid = (r <= 4'h3) || (r >= 4'h8 && r <= 4'hd);
  endfunction : range_valid
endpackage : doc_pkg

// ==== doc_output_setup.sv ====
// output setup register with digital slew limiter
// assumes writes arrive decoded from the serial frame, same clock domain
`timescale 1ns/1ns
// Function
// - the 3-bit step code picks 4,12,64,120,256,500,1820 or 2048 lsb, reset 0.
// - the 4-bit rate code picks the update rate from 240 kHz to 16 Hz, reset 6.
// - while slewing the output moves one step per update tick.
// - bit 8 chooses ramping toward a new code or applying it at once.
// - bit 7 selects the external current resistor when set.
// - bit 6 enables the output terminal drive.
// - bit 5 powers the core and amplifiers without enabling the output.
// - bit 4 enables the 20 percent voltage overrange.
// - a changed range field starts a refresh, pending flag held till done.
// - a write with an undefined range code is ignored entirely.
// - readback bit 21 is the inverted live fault line.
// - range codes 0-3 are voltage, 8-13 current, others undefined.
module doc_output_setup
  import doc_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_code_load,
  input wire logic [15:0] i_target_code,
  input wire logic i_fault_n,
  output logic [23:0] o_rd_data,
  output logic [15:0] o_out_code,
  output logic o_slewing,
  output logic o_calib_refresh_pending,
  output logic [3:0] o_range,
  output logic o_overrange_extend,
  output logic o_buffers_on,
  output logic o_output_drive_on,
  output logic o_external_resistor_select
);
  // ==========================================================
  // configuration register
  logic [2:0] step_reg, step_next;
  logic [3:0] rate_reg, rate_next;
  logic slew_limit_on_reg, slew_limit_on_next;
  logic ext_res_reg, ext_res_next;
  logic out_en_reg, out_en_next;
  logic buf_en_reg, buf_en_next;
  logic ovr_reg, ovr_next;
  logic [3:0] range_reg, range_next;
  logic start_refresh;
  logic [1:0] fault_sync_reg;
  logic [23:0] rd_reg, rd_next;

  always_comb begin
    step_next = step_reg;
    rate_next = rate_reg;
    slew_limit_on_next = slew_limit_on_reg;
    ext_res_next = ext_res_reg;
    out_en_next = out_en_reg;
    buf_en_next = buf_en_reg;
    ovr_next = ovr_reg;
    range_next = range_reg;
    start_refresh = 1'b0;
    if (i_wr_en && i_wr_addr == OUTPUT_SETUP_ADDR
        && range_valid(i_wr_data[3:0])) begin
      step_next = i_wr_data[STEP_LSB +: 3];
      rate_next = i_wr_data[RATE_LSB +: 4];
      slew_limit_on_next = i_wr_data[SLEW_ON_BIT];
      ext_res_next = i_wr_data[EXT_RES_BIT];
      out_en_next = i_wr_data[OUT_EN_BIT];
      buf_en_next = i_wr_data[BUF_EN_BIT];
      ovr_next = i_wr_data[OVR_BIT];
      range_next = i_wr_data[3:0];
      start_refresh = (i_wr_data[3:0] != range_reg);
    end
  end

  always_comb begin
    rd_next = 24'h00_0000;
    rd_next[FAULT_BIT] = ~fault_sync_reg[1];
    rd_next[ADDR_LSB +: 5] = OUTPUT_SETUP_ADDR;
    rd_next[STEP_LSB +: 3] = step_next;
    rd_next[RATE_LSB +: 4] = rate_next;
    rd_next[SLEW_ON_BIT] = slew_limit_on_next;
    rd_next[EXT_RES_BIT] = ext_res_next;
    rd_next[OUT_EN_BIT] = out_en_next;
    rd_next[BUF_EN_BIT] = buf_en_next;
    rd_next[OVR_BIT] = ovr_next;
    rd_next[3:0] = range_next;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      step_reg <= STEP_RESET;
      rate_reg <= RATE_RESET;
      slew_limit_on_reg <= 1'b0;
      ext_res_reg <= 1'b0;
      out_en_reg <= 1'b0;
      buf_en_reg <= 1'b0;
      ovr_reg <= 1'b0;
      range_reg <= RANGE_RESET;
      fault_sync_reg <= 2'b11;
      rd_reg <= OUTPUT_SETUP_RESET;
    end else begin
      step_reg <= step_next;
      rate_reg <= rate_next;
      slew_limit_on_reg <= slew_limit_on_next;
      ext_res_reg <= ext_res_next;
      out_en_reg <= out_en_next;
      buf_en_reg <= buf_en_next;
      ovr_reg <= ovr_next;
      range_reg <= range_next;
      fault_sync_reg <= {fault_sync_reg[0], i_fault_n};
      rd_reg <= rd_next;
    end
  end

  // ==========================================================
  // calibration refresh timer
  logic [31:0] ref_cnt_reg, ref_cnt_next;
  logic pend_reg, pend_next;

  always_comb begin
    ref_cnt_next = ref_cnt_reg;
    pend_next = pend_reg;
    if (start_refresh) begin
      pend_next = 1'b1;
      ref_cnt_next = 32'(REFRESH_CYCLES - 1);
    end else if (pend_reg) begin
      if (ref_cnt_reg == 32'h0000_0000) begin
        pend_next = 1'b0;
      end else begin
        ref_cnt_next = ref_cnt_reg - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ref_cnt_reg <= 32'h0000_0000;
      pend_reg <= 1'b0;
    end else begin
      ref_cnt_reg <= ref_cnt_next;
      pend_reg <= pend_next;
    end
  end

  // ==========================================================
  // slew limiter
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [15:0] code_reg, code_next;
  logic [15:0] tgt_reg, tgt_next;
  logic slewing_reg, slewing_next;
  logic [31:0] period;
  logic [15:0] step;
  logic [16:0] diff;

  always_comb begin
    period = 32'(CLK_HZ / rate_hz(rate_reg));
    step = step_lsb(step_reg);
    tick_cnt_next = tick_cnt_reg;
    code_next = code_reg;
    tgt_next = tgt_reg;
    slewing_next = slewing_reg;
    diff = 17'h0_0000;
    if (i_code_load) begin
      tgt_next = i_target_code;
      if (slew_limit_on_reg) begin
        slewing_next = (i_target_code != code_reg);
        tick_cnt_next = 32'h0000_0000;
      end else begin
        code_next = i_target_code;
        slewing_next = 1'b0;
      end
    end else if (slewing_reg) begin
      if (tick_cnt_reg >= period - 32'h0000_0001) begin
        tick_cnt_next = 32'h0000_0000;
        if (tgt_reg > code_reg) begin
          diff = {1'b0, tgt_reg} - {1'b0, code_reg};
        end else begin
          diff = {1'b0, code_reg} - {1'b0, tgt_reg};
        end
        if (diff <= {1'b0, step}) begin
          code_next = tgt_reg;
          slewing_next = 1'b0;
        end else if (tgt_reg > code_reg) begin
          code_next = code_reg + step;
        end else begin
          code_next = code_reg - step;
        end
      end else begin
        tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tick_cnt_reg <= 32'h0000_0000;
      code_reg <= 16'h0000;
      tgt_reg <= 16'h0000;
      slewing_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      code_reg <= code_next;
      tgt_reg <= tgt_next;
      slewing_reg <= slewing_next;
    end
  end

  // ==========================================================
  // outputs
  assign o_rd_data = rd_reg;
  assign o_out_code = code_reg;
  assign o_slewing = slewing_reg;
  assign o_calib_refresh_pending = pend_reg;
  assign o_range = range_reg;
  assign o_overrange_extend = ovr_reg;
  assign o_buffers_on = buf_en_reg;
  assign o_output_drive_on = out_en_reg;
  assign o_external_resistor_select = ext_res_reg;
endmodule : doc_output_setup

// ==== doc_setup_props.sv ====
// checker on the output setup ports
// assumes bind onto doc_output_setup, one clock, sync reset
`timescale 1ns/1ns
module doc_setup_props #(
  parameter int REFRESH_CYCLES = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_code_load,
  input wire logic [15:0] i_target_code,
  input wire logic i_fault_n,
  input wire logic [23:0] o_rd_data,
  input wire logic [15:0] o_out_code,
  input wire logic o_slewing,
  input wire logic o_calib_refresh_pending,
  input wire logic [3:0] o_range
);
  localparam int LO = REFRESH_CYCLES - 7;
  localparam int HI = REFRESH_CYCLES - 7;
  wire logic acc = i_wr_en && i_wr_addr == 5'h06;
  wire logic vld = i_wr_data[3:2] == 2'h0 ||
    (i_wr_data[3] && i_wr_data[2:0] <= 3'h5);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence hold_s;
    o_calib_refresh_pending [*8];
  endsequence
  // ==========================================================
  // properties
  reset_value_a: assert property (disable iff (1'b0)
    i_rst |=> o_rd_data[20:0] == 21'h06_0c00 && o_out_code == 16'h0000)
    else $error("reset value wrong");
  fault_view_a: assert property (
    $stable(i_fault_n) [*4] |-> o_rd_data[21] == !i_fault_n)
    else $error("fault bit wrong");
  write_take_a: assert property (
    acc && vld |=> o_rd_data[15:0] == $past(i_wr_data))
    else $error("write not taken");
  bad_range_a: assert property (
    acc && !vld |=> $stable(o_rd_data[15:0]))
    else $error("bad range write taken");
  range_mirror_a: assert property (
    o_range == o_rd_data[3:0]) else $error("range output wrong");
  refresh_start_a: assert property (
    acc && vld && i_wr_data[3:0] != o_range |=> o_calib_refresh_pending)
    else $error("refresh not started");
  refresh_hold_a: assert property (
    $rose(o_calib_refresh_pending) |-> hold_s ##[LO:HI]
    !o_calib_refresh_pending) else $error("refresh length wrong");
  direct_load_a: assert property (
    i_code_load && !o_rd_data[8] && !i_wr_en |=>
    o_out_code == $past(i_target_code) && !o_slewing)
    else $error("direct load wrong");
  ramp_start_a: assert property (
    i_code_load && o_rd_data[8] && !i_wr_en &&
    i_target_code != o_out_code |=> o_slewing)
    else $error("ramp not started");
endmodule : doc_setup_props

// ==== doc_host_model.sv ====
// host model issuing output setup writes
// assumes strobes launched on the falling clock edge
`timescale 1ns/1ns
module doc_host_model (
  input wire logic i_sys_clk,
  output logic o_wr_en,
  output logic [4:0] o_wr_addr,
  output logic [15:0] o_wr_data
);
  logic [15:0] last_q = 16'h0000;
  initial begin
    o_wr_en = 1'b0;
    o_wr_addr = 5'h1f;
    o_wr_data = 16'hffff;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (d[6] && !last_q[6]) repeat (5001) @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    o_wr_en = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(negedge i_sys_clk);
    o_wr_en = 1'b0;
    o_wr_addr = ~a;
    o_wr_data = ~d;
    if (a == 5'h06) last_q = d;
  endtask : wr
endmodule : doc_host_model

// ==== dac_output_config_slew_test.sv ====
// self-checking bench for the output setup block
// assumes the host model and checker files compiled first
`timescale 1ns/1ns
module dac_output_config_slew_test;
  localparam int REFRESH_CYCLES = 8;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_code_load = 1'b0;
  logic [15:0] i_target_code = 16'h0000;
  logic i_fault_n = 1'b1;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [15:0] wr_data, o_out_code, reg_m;
  logic [23:0] o_rd_data;
  logic [3:0] o_range;
  logic o_slewing, o_calib_refresh_pending, o_overrange_extend;
  logic o_buffers_on, o_output_drive_on, o_external_resistor_select;
  int errors = 0, checks = 0, seed = 32'hf117, cur_m, tgt, i, s, n;
  int stp[8] = '{4, 12, 64, 120, 256, 500, 1820, 2048};
  int hz[8] = '{240000, 200000, 150000, 128000, 64000, 32000, 16000, 8000};
  logic [31:0] v;
  always #20 i_sys_clk = ~i_sys_clk;
  doc_host_model u_host (.i_sys_clk(i_sys_clk), .o_wr_en(wr_en),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data));
  doc_output_setup #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wr_en(wr_en),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_code_load(i_code_load),
    .i_target_code(i_target_code), .i_fault_n(i_fault_n),
    .o_rd_data(o_rd_data), .o_out_code(o_out_code), .o_slewing(o_slewing),
    .o_calib_refresh_pending(o_calib_refresh_pending),
    .o_range(o_range), .o_overrange_extend(o_overrange_extend),
    .o_buffers_on(o_buffers_on), .o_output_drive_on(o_output_drive_on),
    .o_external_resistor_select(o_external_resistor_select));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic ok;
    ok = a == 5'h06 && (d[3:2] == 2'h0 || (d[3] && d[2:0] <= 3'h5));
    u_host.wr(a, d);
    chk(o_calib_refresh_pending, ok && d[3:0] != reg_m[3:0]);
    if (ok) reg_m = d;
    chk(o_rd_data, {~i_fault_n, 5'h06, reg_m});
    chk({o_external_resistor_select, o_output_drive_on, o_buffers_on,
      o_overrange_extend, o_range}, reg_m[7:0]);
    for (n = 0; n < 40 && o_calib_refresh_pending !== 1'b0; n++)
      @(negedge i_sys_clk);
    if (n == 40) begin
      errors++;
      conclude();
    end
  endtask : wr
  task automatic load(input logic [15:0] t);
    i_target_code = t;
    i_code_load = 1'b1;
    @(negedge i_sys_clk);
    i_code_load = 1'b0;
    i_target_code = ~t;
  endtask : load
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_rst = 1'b0;
    chk(o_rd_data, 24'h06_0c00);
    reg_m = 16'h0c00;
    for (i = 0; i < 16; i++) begin
      v = $random(seed);
      // output enable only once buffers are on
      wr(5'h06, {v[15:7], v[6] & reg_m[5], v[5:4], i[3:0]});
    end
    wr(5'h05, 16'h0000);
    i_fault_n = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    chk(o_rd_data[21], 1'b1);
    i_fault_n = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    wr(5'h06, {reg_m[15:9], 1'b0, reg_m[7:0]});
    v = $random(seed);
    load({1'b0, v[14:0]});
    chk(o_out_code, {1'b0, v[14:0]});
    cur_m = int'(v[14:0]);
    for (i = 0; i < 8; i++) begin
      wr(5'h06, {i[2:0], i[3:0], 1'b1, reg_m[7:0]});
      tgt = cur_m + 2 * stp[i] + 1;
      load(tgt[15:0]);
      chk(o_slewing, 1'b1);
      for (s = 0; s < 3; s++) begin
        for (n = 0; n < 4000 && o_out_code === cur_m[15:0]; n++)
          @(negedge i_sys_clk);
        if (n == 4000) begin
          errors++;
          conclude();
        end
        cur_m = (tgt - cur_m > stp[i]) ? cur_m + stp[i] : tgt;
        chk(o_out_code, cur_m[15:0]);
        if (s == 1) chk(24'(n), 24'(25_000_000 / hz[i]));
      end
      chk(o_slewing, 1'b0);
    end
    // descending ramp at a slow rate code
    wr(5'h06, {3'h7, 4'h8, 1'b1, reg_m[7:0]});
    tgt = cur_m - stp[7] - 1;
    load(tgt[15:0]);
    chk(o_slewing, 1'b1);
    for (s = 0; s < 2; s++) begin
      for (n = 0; n < 7000 && o_out_code === cur_m[15:0]; n++)
        @(negedge i_sys_clk);
      if (n == 7000) begin
        errors++;
        conclude();
      end
      cur_m = (cur_m - tgt > stp[7]) ? cur_m - stp[7] : tgt;
      chk(o_out_code, cur_m[15:0]);
      chk(24'(n), 24'(25_000_000 / 4000));
    end
    chk(o_slewing, 1'b0);
    conclude();
  end
endmodule : dac_output_config_slew_test
bind doc_output_setup doc_setup_props #(.REFRESH_CYCLES(REFRESH_CYCLES))
  u_props (.*);
